// >>> hdl/lcc_link_ctl.sv
`include "lcc_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module lcc_link_ctl
  import lcc_pkg::*;
(
  input wire logic sys_clk, // 50 MHz clock
  input wire logic arst_n, // async reset, active low
  input wire logic rx_valid, // received frame strobe
  input var lcc_frm_t rx_frame, // received frame fields
  input wire logic [`LCC_SEQ_W-1:0] window_k, // max outstanding info frames
  input wire logic cmd_valid, // local command offered
  input var lcc_cmd_t cmd_kind, // local command
  input wire logic [`LCC_SEQ_W-1:0] cmd_nr, // seq for selective reject
  output logic cmd_ready, // command taken when high with valid
  input wire logic info_valid, // new info frame offered
  output logic info_ready, // info frame taken when high with valid and cmd_valid low
  output logic tx_valid, // frame to send
  input wire logic tx_ready, // frame taken by transmitter
  output lcc_frm_t tx_frame, // frame to send
  output logic link_up, // balanced mode active
  output logic [`LCC_SEQ_W-1:0] send_state_var, // next send number
  output logic [`LCC_SEQ_W-1:0] receive_state_var, // next expected number
  output logic [`LCC_CNT_W-1:0] unack_cnt, // info frames awaiting ack
  output logic selrej_busy, // a selective reject is pending
  output logic rtx_valid, // one-cycle resend request
  output logic [`LCC_SEQ_W-1:0] rtx_ns, // send number to resend
  output logic bad_ns // one-cycle invalid send number flag
);

  lcc_ctl_st_t s_r;
  lcc_ctl_st_t s_nxt;
  logic buf_in_ready;
  logic push;
  logic cmd_take;
  logic info_take;
  lcc_seq_t ns_off;
  lcc_seq_t ack_adv;

  lcc_buf2 #(.W(`LCC_FRM_W)) u_buf (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .in_valid(s_r.out_v),
    .in_ready(buf_in_ready),
    .in_data(s_r.out),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_frame)
  );

  assign push = s_r.out_v && buf_in_ready;
  assign cmd_take = cmd_valid && s_r.cmd_ready;
  assign info_take = info_valid && s_r.info_ready;
  assign ns_off = rx_frame.ns - s_r.last_nr;
  assign ack_adv = rx_frame.nr - s_r.va;

  assign cmd_ready = s_r.cmd_ready;
  assign info_ready = s_r.info_ready;
  assign link_up = s_r.link_up;
  assign send_state_var = s_r.vs;
  assign receive_state_var = s_r.vr;
  assign unack_cnt = s_r.unack;
  assign selrej_busy = s_r.selrej_busy;
  assign rtx_valid = s_r.rtx_valid;
  assign rtx_ns = s_r.rtx_ns;
  assign bad_ns = s_r.bad_ns;

  // builds an unnumbered frame; carries no sequence change and no info
  function automatic lcc_frm_t unnum(input lcc_kind_t k);
    lcc_frm_t f;
    f = '0;
    f.kind = k;
    f.pf = 1'b1;
    f.has_info = 1'b0;
    return f;
  endfunction

  always_comb begin
    s_nxt = s_r;
    s_nxt.rtx_valid = 1'b0;
    s_nxt.bad_ns = 1'b0;
    if (push) begin
      s_nxt.out_v = 1'b0;
    end

    // received frames
    if (rx_valid) begin
      case (rx_frame.kind)
        FRM_SET_BAL: begin
          s_nxt.ack_pend = 1'b1;
          s_nxt.exec = EX_SET;
        end
        FRM_TEARDOWN: begin
          if (s_r.state == ST_DISCON) begin
            s_nxt.status_pend = 1'b1;
          end else begin
            s_nxt.ack_pend = 1'b1;
            s_nxt.exec = EX_TEAR;
          end
        end
        FRM_RESET_RX: begin
          if (s_r.state == ST_BALANCED) begin
            s_nxt.ack_pend = 1'b1;
            s_nxt.exec = EX_RESET;
          end else if (s_r.state == ST_DISCON) begin
            s_nxt.status_pend = 1'b1;
          end
        end
        FRM_UNNUM_ACK: begin
          case (s_r.state)
            ST_WAIT_SET: begin
              s_nxt.state = ST_BALANCED;
              s_nxt.vs = `LCC_SEQ_RST;
              s_nxt.vr = `LCC_SEQ_RST;
              s_nxt.va = `LCC_SEQ_RST;
              s_nxt.last_nr = `LCC_SEQ_RST;
            end
            ST_WAIT_RESET: begin
              s_nxt.state = ST_BALANCED;
              s_nxt.vs = `LCC_SEQ_RST;
              s_nxt.va = `LCC_SEQ_RST;
            end
            ST_WAIT_TEAR: begin
              s_nxt.state = ST_DISCON;
            end
            default: begin
            end
          endcase
        end
        FRM_DISCON_MODE: begin
          if (s_r.state != ST_DISCON) begin
            s_nxt.state = ST_DISCON;
          end
        end
        FRM_INFO: begin
          if (s_r.state == ST_BALANCED) begin
            if (ns_off >= window_k) begin
              s_nxt.bad_ns = 1'b1;
            end else begin
              if (rx_frame.ns == s_r.vr) begin
                s_nxt.vr = s_r.vr + 7'h01;
              end
              s_nxt.selrej_mask[rx_frame.ns] = 1'b0;
              if (`LCC_CNT_W'(ack_adv) <= s_r.unack) begin
                s_nxt.va = rx_frame.nr;
                s_nxt.unack = s_r.unack - `LCC_CNT_W'(ack_adv);
              end
            end
          end
        end
        FRM_SEL_REJ: begin
          if (s_r.state == ST_BALANCED) begin
            s_nxt.rtx_valid = 1'b1;
            s_nxt.rtx_ns = rx_frame.nr;
            if (rx_frame.pf && (`LCC_CNT_W'(ack_adv) <= s_r.unack)) begin
              s_nxt.va = rx_frame.nr;
              s_nxt.unack = s_r.unack - `LCC_CNT_W'(ack_adv);
            end
          end
        end
        default: begin
        end
      endcase
    end

    // outgoing frame selection; pending responses go first
    if (!s_nxt.out_v) begin
      if (s_r.ack_pend) begin
        s_nxt.out = unnum(FRM_UNNUM_ACK);
        s_nxt.out_v = 1'b1;
        s_nxt.ack_pend = 1'b0;
      end else if (s_r.status_pend) begin
        s_nxt.out = unnum(FRM_DISCON_MODE);
        s_nxt.out_v = 1'b1;
        s_nxt.status_pend = 1'b0;
      end else if (cmd_take) begin
        case (cmd_kind)
          CMD_CONNECT: begin
            s_nxt.out = unnum(FRM_SET_BAL);
            s_nxt.out_v = 1'b1;
            s_nxt.state = ST_WAIT_SET;
          end
          CMD_DISCONNECT: begin
            if (s_r.state == ST_BALANCED) begin
              s_nxt.out = unnum(FRM_TEARDOWN);
              s_nxt.out_v = 1'b1;
              s_nxt.state = ST_WAIT_TEAR;
            end
          end
          CMD_RESET_RX: begin
            if (s_r.state == ST_BALANCED) begin
              s_nxt.out = unnum(FRM_RESET_RX);
              s_nxt.out_v = 1'b1;
              s_nxt.state = ST_WAIT_RESET;
            end
          end
          CMD_SEL_REJ: begin
            if (s_r.state == ST_BALANCED) begin
              s_nxt.out = '0;
              s_nxt.out.kind = FRM_SEL_REJ;
              s_nxt.out.nr = cmd_nr;
              s_nxt.out_v = 1'b1;
              s_nxt.last_nr = cmd_nr;
              s_nxt.selrej_mask[cmd_nr] = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end else if (info_take) begin
        s_nxt.out = '0;
        s_nxt.out.kind = FRM_INFO;
        s_nxt.out.ns = s_r.vs;
        s_nxt.out.nr = s_nxt.vr;
        s_nxt.out.has_info = 1'b1;
        s_nxt.out_v = 1'b1;
        s_nxt.last_nr = s_nxt.vr;
        s_nxt.vs = s_r.vs + 7'h01;
        s_nxt.unack = s_r.unack + 8'h01;
      end
    end

    // accepted command runs once its acknowledge has left the station
    if (s_r.exec != EX_NONE && !s_r.ack_pend && !s_r.out_v && !tx_valid) begin
      case (s_r.exec)
        EX_SET: begin
          s_nxt.state = ST_BALANCED;
          s_nxt.vs = `LCC_SEQ_RST;
          s_nxt.vr = `LCC_SEQ_RST;
          s_nxt.va = `LCC_SEQ_RST;
          s_nxt.last_nr = `LCC_SEQ_RST;
        end
        EX_TEAR: begin
          s_nxt.state = ST_DISCON;
        end
        EX_RESET: begin
          s_nxt.vr = `LCC_SEQ_RST;
        end
        default: begin
        end
      endcase
      s_nxt.exec = EX_NONE;
    end

    s_nxt.link_up = (s_nxt.state == ST_BALANCED);
    s_nxt.selrej_busy = |s_nxt.selrej_mask;
    s_nxt.cmd_ready = !s_nxt.out_v && !s_nxt.ack_pend && !s_nxt.status_pend
                      && (s_nxt.exec == EX_NONE);
    s_nxt.info_ready = s_nxt.cmd_ready && (s_nxt.state == ST_BALANCED)
                       && (s_nxt.unack < {1'b0, window_k});
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

`default_nettype wire

// >>> hdl/lcc_defines.svh
`ifndef LCC_DEFINES_SVH
`define LCC_DEFINES_SVH

// sequence numbers run modulo 128
`define LCC_SEQ_W 7
`define LCC_SEQ_N 128
`define LCC_CNT_W 8

// reset values
`define LCC_SEQ_RST 7'h00
`define LCC_CNT_RST 8'h00

// frame field layout, msb first: kind, send seq, recv seq, poll/final, has info
`define LCC_KIND_W 3
`define LCC_FRM_W 19

`endif

// >>> hdl/lcc_pkg.sv
`include "lcc_defines.svh"

package lcc_pkg;

  typedef logic [`LCC_SEQ_W-1:0] lcc_seq_t;
  typedef logic [`LCC_CNT_W-1:0] lcc_cnt_t;

  typedef enum logic [`LCC_KIND_W-1:0] {
    FRM_INFO        = 3'h0,
    FRM_SEL_REJ     = 3'h1,
    FRM_SET_BAL     = 3'h2,
    FRM_TEARDOWN    = 3'h3,
    FRM_RESET_RX    = 3'h4,
    FRM_UNNUM_ACK   = 3'h5,
    FRM_DISCON_MODE = 3'h6,
    FRM_OTHER       = 3'h7
  } lcc_kind_t;

  typedef struct packed {
    lcc_kind_t kind;
    lcc_seq_t ns;
    lcc_seq_t nr;
    logic pf;
    logic has_info;
  } lcc_frm_t;

  // local requests from the station's upper layer
  typedef enum logic [1:0] {
    CMD_CONNECT    = 2'h0,
    CMD_DISCONNECT = 2'h1,
    CMD_RESET_RX   = 2'h2,
    CMD_SEL_REJ    = 2'h3
  } lcc_cmd_t;

  // gray codes along discon -> wait_set -> balanced -> wait_reset -> wait_tear
  typedef enum logic [2:0] {
    ST_DISCON     = 3'b000,
    ST_WAIT_SET   = 3'b001,
    ST_BALANCED   = 3'b011,
    ST_WAIT_RESET = 3'b010,
    ST_WAIT_TEAR  = 3'b110
  } lcc_state_t;

  typedef enum logic [1:0] {
    EX_NONE  = 2'h0,
    EX_SET   = 2'h1,
    EX_TEAR  = 2'h2,
    EX_RESET = 2'h3
  } lcc_exec_t;

  typedef struct packed {
    lcc_state_t state;
    lcc_exec_t exec;
    logic ack_pend;
    logic status_pend;
    logic out_v;
    lcc_frm_t out;
    lcc_seq_t vs;
    lcc_seq_t vr;
    lcc_seq_t va;
    lcc_seq_t last_nr;
    lcc_cnt_t unack;
    logic [`LCC_SEQ_N-1:0] selrej_mask;
    logic selrej_busy;
    logic cmd_ready;
    logic info_ready;
    logic link_up;
    logic rtx_valid;
    lcc_seq_t rtx_ns;
    logic bad_ns;
  } lcc_ctl_st_t;

endpackage

// >>> hdl/lcc_buf2.sv
`timescale 1ns/1ps
`default_nettype none

// two-entry buffer; outputs come straight from flip-flops
module lcc_buf2 #(
  parameter int W = 8
) (
  input wire logic sys_clk, // clock
  input wire logic arst_n, // async reset, active low
  input wire logic in_valid, // word offered
  output logic in_ready, // room for a word
  input wire logic [W-1:0] in_data, // offered word
  output logic out_valid, // head word valid
  input wire logic out_ready, // drain side takes head
  output logic [W-1:0] out_data // head word
);

  typedef struct packed {
    logic [W-1:0] head;
    logic [W-1:0] tail;
    logic hv;
    logic tv;
  } buf_st_t;

  buf_st_t s_r;
  buf_st_t s_nxt;

  assign in_ready = ~s_r.tv;
  assign out_valid = s_r.hv;
  assign out_data = s_r.head;

  always_comb begin
    s_nxt = s_r;
    if (s_r.hv && out_ready) begin
      s_nxt.head = s_r.tail;
      s_nxt.hv = s_r.tv;
      s_nxt.tv = 1'b0;
    end
    if (in_valid && !s_r.tv) begin
      if (!s_nxt.hv) begin
        s_nxt.head = in_data;
        s_nxt.hv = 1'b1;
      end else begin
        s_nxt.tail = in_data;
        s_nxt.tv = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

`default_nettype wire

// >>> verification/lcc_link_ctl_properties.sv
`include "lcc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module lcc_link_ctl_properties
  import lcc_pkg::*;
(
  input wire logic sys_clk, // clock
  input wire logic arst_n, // reset
  input wire logic rx_valid, // rx strobe
  input var lcc_frm_t rx_frame, // rx frame
  input wire logic [`LCC_SEQ_W-1:0] window_k, // window
  input wire logic cmd_valid, // cmd offered
  input var lcc_cmd_t cmd_kind, // cmd
  input wire logic [`LCC_SEQ_W-1:0] cmd_nr, // cmd seq
  input wire logic cmd_ready, // cmd taken
  input wire logic info_valid, // info offered
  input wire logic info_ready, // info taken
  input wire logic tx_valid, // tx valid
  input wire logic tx_ready, // tx taken
  input var lcc_frm_t tx_frame, // tx frame
  input wire logic link_up, // balanced
  input wire logic [`LCC_SEQ_W-1:0] send_state_var, // vs
  input wire logic [`LCC_SEQ_W-1:0] receive_state_var, // vr
  input wire logic [`LCC_CNT_W-1:0] unack_cnt, // unacked
  input wire logic selrej_busy, // selective_reject pending
  input wire logic rtx_valid, // resend pulse
  input wire logic [`LCC_SEQ_W-1:0] rtx_ns, // resend seq
  input wire logic bad_ns // bad seq pulse
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  sequence s_conn_take;
    cmd_valid && cmd_ready && cmd_kind == CMD_CONNECT && !tx_valid;
  endsequence
  sequence s_set_in;
    rx_valid && rx_frame.kind == FRM_SET_BAL && cmd_ready && !tx_valid;
  endsequence
  AST_NO_INFO:
  assert property (tx_valid && tx_frame.kind inside {FRM_SET_BAL, FRM_TEARDOWN,
    FRM_RESET_RX, FRM_UNNUM_ACK, FRM_DISCON_MODE} |-> !tx_frame.has_info)
    else $error("unnumbered frame with info");
  AST_CONNECT:
  assert property (s_conn_take |-> ##2 tx_valid && tx_frame.kind == FRM_SET_BAL)
    else $error("connect frame missing");
  AST_ACK_SET:
  assert property (s_set_in |-> ##3 tx_valid && tx_frame.kind == FRM_UNNUM_ACK)
    else $error("ack to set missing");
  AST_UP_ZERO:
  assert property ($rose(link_up) |-> send_state_var == 7'h00)
    else $error("send var not zero on mode entry");
  AST_UNACK_KEEP:
  assert property ($fell(link_up) |-> $stable(unack_cnt))
    else $error("unacked count lost");
  AST_EXEC_LATE:
  assert property (tx_valid && tx_frame.kind == FRM_UNNUM_ACK |=> $stable(link_up))
    else $error("mode changed before ack sent");
  AST_SELECTIVE_REJECT:
  assert property (rx_valid && rx_frame.kind == FRM_SEL_REJ && link_up
    |=> rtx_valid && rtx_ns == $past(rx_frame.nr))
    else $error("resend request wrong");
  AST_BAD_CAUSE:
  assert property (bad_ns |-> $past(rx_valid) && $past(rx_frame.kind) == FRM_INFO)
    else $error("bad seq flag without info frame");
  AST_DM_KEEP:
  assert property (rx_valid && rx_frame.kind == FRM_DISCON_MODE && !link_up
    |=> $stable(send_state_var) && $stable(receive_state_var))
    else $error("state vars moved on unnumbered frame");
  AST_TX_HOLD:
  assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame))
    else $error("tx frame dropped while stalled");
endmodule
bind lcc_link_ctl lcc_link_ctl_properties u_props (.sys_clk(sys_clk), .arst_n(arst_n),
  .rx_valid(rx_valid), .rx_frame(rx_frame), .window_k(window_k), .cmd_valid(cmd_valid),
  .cmd_kind(cmd_kind), .cmd_nr(cmd_nr), .cmd_ready(cmd_ready), .info_valid(info_valid),
  .info_ready(info_ready), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_frame(tx_frame),
  .link_up(link_up), .send_state_var(send_state_var),
  .receive_state_var(receive_state_var), .unack_cnt(unack_cnt),
  .selrej_busy(selrej_busy), .rtx_valid(rtx_valid), .rtx_ns(rtx_ns), .bad_ns(bad_ns));
`default_nettype wire

// >>> verification/lcc_peer.sv
`timescale 1ns/1ps
`default_nettype none
module lcc_peer
  import lcc_pkg::*;
(
  input wire logic sys_clk, // clock
  input wire logic stall, // hold off transmitter
  input wire logic tx_valid, // frame offered
  input var lcc_frm_t tx_frame, // frame offered
  output logic tx_ready, // frame taken
  output logic rx_valid, // frame to station
  output lcc_frm_t rx_frame // frame to station
);
  lcc_frm_t got;
  int n_got = 0;
  assign tx_ready = !stall;
  initial begin
    rx_valid = 1'b0;
    rx_frame = '0;
  end
  function automatic lcc_frm_t uf(input lcc_kind_t k);
    uf = '{k, 7'h00, 7'h00, 1'b1, 1'b0};
  endfunction
  task automatic put(input lcc_frm_t f);
    @(posedge sys_clk);
    #1;
    rx_valid = 1'b1;
    rx_frame = f;
    @(posedge sys_clk);
    #1;
    rx_valid = 1'b0;
    rx_frame = ~f;
  endtask
  // commands are acknowledged a few cycles after they arrive
  always @(posedge sys_clk) begin
    if (tx_valid && tx_ready) begin
      got = tx_frame;
      n_got++;
      if (tx_frame.kind inside {FRM_SET_BAL, FRM_TEARDOWN, FRM_RESET_RX}) begin
        repeat (2) @(posedge sys_clk);
        put(uf(FRM_UNNUM_ACK));
      end
    end
  end
endmodule
`default_nettype wire

// >>> verification/lcc_link_ctl_test.sv
`timescale 1ns/1ps
`default_nettype none
module lcc_link_ctl_test
  import lcc_pkg::*;
;
  logic sys_clk = 1'b0, arst_n = 1'b0, stall = 1'b0;
  logic cmd_valid = 1'b0, info_valid = 1'b0;
  lcc_cmd_t cmd_kind = CMD_CONNECT;
  lcc_seq_t cmd_nr = 7'h00;
  logic rx_valid, cmd_ready, info_ready, tx_valid, tx_ready, link_up, selrej_busy;
  logic rtx_valid, bad_ns;
  lcc_frm_t rx_frame, tx_frame;
  logic [6:0] vs, vr, rtx_ns;
  logic [7:0] unack_cnt;
  int err_total = 0, checks_done = 0, tmo = 0;
  lcc_link_ctl u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .rx_valid(rx_valid),
    .rx_frame(rx_frame), .window_k(7'h04), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
    .cmd_nr(cmd_nr), .cmd_ready(cmd_ready), .info_valid(info_valid),
    .info_ready(info_ready), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_frame(tx_frame), .link_up(link_up), .send_state_var(vs),
    .receive_state_var(vr), .unack_cnt(unack_cnt), .selrej_busy(selrej_busy),
    .rtx_valid(rtx_valid), .rtx_ns(rtx_ns), .bad_ns(bad_ns));
  lcc_peer u_peer (.sys_clk(sys_clk), .stall(stall), .tx_valid(tx_valid),
    .tx_frame(tx_frame), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_frame(rx_frame));
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    tmo++;
    if (tmo == 20000) begin
      err_total++;
      test_done();
    end
  end
  task automatic chk(input logic [18:0] g, input logic [18:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic cmd(input lcc_cmd_t k, input lcc_seq_t nr);
    cmd_kind = k;
    cmd_nr = nr;
    cmd_valid = 1'b1;
    for (int i = 0; i < 50 && cmd_ready !== 1'b1; i++) cyc(1);
    cyc(1);
    cmd_valid = 1'b0;
  endtask
  task automatic info();
    info_valid = 1'b1;
    for (int i = 0; i < 50 && info_ready !== 1'b1; i++) cyc(1);
    cyc(1);
    info_valid = 1'b0;
  endtask
  task automatic wt_got(input int n);
    for (int i = 0; i < 60 && u_peer.n_got <= n; i++) cyc(1);
  endtask
  task automatic wt_link(input logic e);
    for (int i = 0; i < 60 && link_up !== e; i++) cyc(1);
  endtask
  function automatic lcc_frm_t fi(input lcc_kind_t k, input lcc_seq_t ns, input lcc_seq_t nr);
    fi = '{k, ns, nr, 1'b0, k == FRM_INFO};
  endfunction
  task automatic t_conn();
    int n = u_peer.n_got;
    chk(link_up, 0);
    cmd(CMD_CONNECT, 7'h00);
    wt_got(n);
    chk(u_peer.got, u_peer.uf(FRM_SET_BAL));
    wt_link(1);
    chk({vs, vr}, 0);
    $display("connect done");
  endtask
  task automatic t_info();
    int n = u_peer.n_got;
    stall = 1'b1;
    info();
    cyc(5);
    chk({tx_valid, tx_frame.kind, tx_frame.ns, tx_frame.has_info}, {1'b1, FRM_INFO, 8'h01});
    stall = 1'b0;
    info();
    wt_got(n + 1);
    chk(u_peer.got.ns, 1);
    chk({vs, unack_cnt}, {7'h02, 8'h02});
    $display("info done");
  endtask
  task automatic t_selective_reject();
    int n = u_peer.n_got;
    u_peer.put(fi(FRM_SEL_REJ, 7'h00, 7'h01));
    chk({rtx_valid, rtx_ns}, {1'b1, 7'h01});
    cyc(1);
    chk(rtx_valid, 0);
    cmd(CMD_SEL_REJ, 7'h00);
    wt_got(n);
    chk({u_peer.got.kind, selrej_busy}, {FRM_SEL_REJ, 1'b1});
    u_peer.put(fi(FRM_INFO, 7'h00, 7'h00));
    chk({selrej_busy, vr}, 8'h01);
    u_peer.put(fi(FRM_INFO, 7'h03, 7'h00));
    chk(bad_ns, 0);
    u_peer.put(fi(FRM_INFO, 7'h04, 7'h00));
    chk(bad_ns, 1);
    $display("selective reject done");
  endtask
  task automatic t_reset();
    int n = u_peer.n_got;
    u_peer.put(u_peer.uf(FRM_RESET_RX));
    wt_got(n);
    chk(u_peer.got, u_peer.uf(FRM_UNNUM_ACK));
    cyc(3);
    chk({vs, vr}, {7'h02, 7'h00});
    cmd(CMD_RESET_RX, 7'h00);
    wt_got(n + 1);
    chk(u_peer.got, u_peer.uf(FRM_RESET_RX));
    cyc(8);
    chk({link_up, vs}, 8'h80);
    $display("reset done");
  endtask
  task automatic t_tear();
    int n = u_peer.n_got;
    cmd(CMD_DISCONNECT, 7'h00);
    wt_got(n);
    chk(u_peer.got, u_peer.uf(FRM_TEARDOWN));
    // let the peer's acknowledge land before driving the receive port again
    cyc(6);
    wt_link(0);
    chk(unack_cnt, 2);
    u_peer.put(u_peer.uf(FRM_DISCON_MODE));
    u_peer.put(u_peer.uf(FRM_SET_BAL));
    wt_got(n + 1);
    chk(u_peer.got, u_peer.uf(FRM_UNNUM_ACK));
    wt_link(1);
    chk({vs, vr, unack_cnt}, {14'h0000, 8'h02});
    u_peer.put(u_peer.uf(FRM_TEARDOWN));
    chk(link_up, 1);
    wt_got(n + 2);
    chk(u_peer.got, u_peer.uf(FRM_UNNUM_ACK));
    wt_link(0);
    u_peer.put(u_peer.uf(FRM_TEARDOWN));
    wt_got(n + 3);
    chk(u_peer.got, u_peer.uf(FRM_DISCON_MODE));
    $display("teardown done");
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    #1;
    arst_n = 1'b1;
    cyc(1);
    t_conn();
    t_info();
    t_selective_reject();
    t_reset();
    t_tear();
    test_done();
  end
endmodule
`default_nettype wire
